/* File: lldc_ctrl.sv */
// Host controller for the low latency DRAM: Avalon slave, command and data sequencer
module lldc_ctrl (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Memory command pins
	output lldc_pkg::lldc_cmd_s mem_cmd,
	// Memory write data pins
	output logic write_data_clock,
	output lldc_pkg::lldc_wbeat_s mem_wbeat,
	output logic mem_dq_oe,
	// Memory read pins
	input wire logic [17:0] mem_dq_in,
	input wire logic read_valid_flag,
	input wire logic [1:0] read_data_strobe
);
	import lldc_pkg::*;
	// ********************************************************************
	// Registers
	// ********************************************************************
	typedef enum {S_IDLE, S_WAIT, S_CMD, S_AY, S_WLAT, S_WDATA, S_RWAIT, S_DONE} lldc_state_e;
	lldc_state_e state_q;
	logic [31:0] ctrl_q, addr_q, wdata_q, rdata_q, refi_q;
	logic [17:0] mode_q;
	logic go_q, busy_q, err_q, done_q;
	logic [1:0] op_q;
	logic [3:0] cnt_q;
	logic [5:0] to_q;
	logic [1:0] beat_q;
	logic [19:0] ref_tmr_q;
	logic ref_pend_q;
	logic [2:0] ref_bank_q;
	logic ack_q;
	logic [31:0] rd_mux;
	logic [2:0] cfg;
	logic mux_mode;
	logic [3:0] trc, rl;
	logic [7:0] bank_busy;
	logic issue;
	logic [2:0] issue_bank;
	logic [2:0] rv_sync_q, dqs_sync_q0, dqs_sync_q1;
	logic [17:0] dq_s0_q, dq_s1_q;
	logic illegal;
	logic start_q, wr_ok;
	assign cfg = mode_q[LLDC_MODE_CFG_LSB +: 3];
	assign mux_mode = mode_q[LLDC_MODE_MUX_BIT]; // RULE_21
	assign trc = lldc_trc(cfg); // RULE_01
	assign rl = lldc_rl(cfg, mux_mode); // RULE_24
	// Burst length eight with configuration 1 or unknown cfg is refused
	assign illegal = (ctrl_q[1:0] == LLDC_OP_MRS) &&
		((addr_q[LLDC_MODE_BL_LSB +: 2] == LLDC_BL8 && addr_q[2:0] == 3'h1) || // RULE_03
		(addr_q[2:0] == 3'h0) || (addr_q[2:0] > 3'h3)); // RULE_02
	// ********************************************************************
	// Avalon slave: one wait cycle, answer on the second edge
	// ********************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end
	assign avs_waitrequest = !ack_q;
	always_comb begin
		case (avs_address)
			LLDC_REG_CTRL: rd_mux = ctrl_q;
			LLDC_REG_ADDR: rd_mux = addr_q;
			LLDC_REG_WDATA: rd_mux = wdata_q;
			LLDC_REG_RDATA: rd_mux = rdata_q;
			LLDC_REG_STATUS: rd_mux = {28'h0, err_q, done_q, ref_pend_q, busy_q || start_q};
			LLDC_REG_MODE: rd_mux = {14'h0, mode_q};
			LLDC_REG_REFI: rd_mux = refi_q;
			default: rd_mux = LLDC_UNMAPPED;
		endcase
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !ack_q) begin
			avs_readdata <= rd_mux;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q <= 32'h0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			refi_q <= LLDC_REFI_CYCLES[31:0];
		end else if (avs_write && ack_q && wr_ok) begin
			case (avs_address)
				LLDC_REG_CTRL: ctrl_q <= avs_writedata;
				LLDC_REG_ADDR: addr_q <= avs_writedata;
				LLDC_REG_WDATA: wdata_q <= avs_writedata;
				LLDC_REG_REFI: refi_q <= avs_writedata;
				default: ;
			endcase
		end
	end
	// Command start pulse from control register bit 31
	// A background refresh does not lock software out of the registers
	assign wr_ok = !busy_q || op_q == LLDC_OP_BANK_REFRESH_CMD;
	assign go_q = avs_write && ack_q && wr_ok && avs_address == LLDC_REG_CTRL &&
		avs_writedata[31];
	// Start held until a refresh in progress or pending has gone
	always_ff @(posedge clock) begin
		if (reset) begin
			start_q <= 1'b0;
		end else if (state_q == S_IDLE && !ref_pend_q && (go_q || start_q)) begin
			start_q <= 1'b0;
		end else if (go_q) begin
			start_q <= 1'b1;
		end
	end
	// ********************************************************************
	// Refresh scheduler
	// ********************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			ref_tmr_q <= 20'h0;
			ref_pend_q <= 1'b0;
		end else begin
			if (ref_tmr_q >= refi_q[19:0]) begin
				ref_tmr_q <= 20'h0;
				ref_pend_q <= 1'b1; // RULE_16
			end else begin
				ref_tmr_q <= ref_tmr_q + 20'h1;
				if (state_q == S_CMD && op_q == LLDC_OP_BANK_REFRESH_CMD) begin
					ref_pend_q <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			ref_bank_q <= 3'h0;
		end else if (state_q == S_CMD && op_q == LLDC_OP_BANK_REFRESH_CMD) begin
			ref_bank_q <= ref_bank_q + 3'h1;
		end
	end
	// ********************************************************************
	// Read pin synchronisers
	// ********************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			rv_sync_q <= 3'h0;
			dqs_sync_q0 <= 3'h0;
			dqs_sync_q1 <= 3'h0;
			dq_s0_q <= 18'h0;
			dq_s1_q <= 18'h0;
		end else begin
			rv_sync_q <= {rv_sync_q[1:0], read_valid_flag};
			dqs_sync_q0 <= {dqs_sync_q0[1:0], read_data_strobe[0]};
			dqs_sync_q1 <= {dqs_sync_q1[1:0], read_data_strobe[1]};
			dq_s0_q <= mem_dq_in;
			dq_s1_q <= dq_s0_q;
		end
	end
	// ********************************************************************
	// Sequencer
	// ********************************************************************
	assign issue = state_q == S_CMD;
	assign issue_bank = (op_q == LLDC_OP_BANK_REFRESH_CMD) ? ref_bank_q : addr_q[23:21];
	lldc_bank_timer u_bank (
		.clock(clock),
		.reset(reset),
		.issue(issue),
		.bank(issue_bank),
		.trc(trc),
		.busy(bank_busy)
	);
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= S_IDLE;
			op_q <= LLDC_OP_READ;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			cnt_q <= 4'h0;
			to_q <= 6'h0;
			beat_q <= 2'h0;
			mode_q <= LLDC_MODE_RESET;
			rdata_q <= 32'h0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (ref_pend_q) begin
						op_q <= LLDC_OP_BANK_REFRESH_CMD;
						busy_q <= 1'b1;
						state_q <= S_WAIT;
					end else if (go_q || start_q) begin
						op_q <= go_q ? avs_writedata[1:0] : ctrl_q[1:0];
						busy_q <= 1'b1;
						done_q <= 1'b0;
						err_q <= 1'b0;
						state_q <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (op_q == LLDC_OP_MRS && illegal) begin
						err_q <= 1'b1;
						state_q <= S_DONE;
					end else if (!bank_busy[issue_bank]) begin // RULE_15 RULE_25
						state_q <= S_CMD;
					end
				end
				S_CMD: begin
					if (op_q == LLDC_OP_MRS) begin
						mode_q <= addr_q[17:0]; // RULE_23
					end
					if (mux_mode && op_q != LLDC_OP_BANK_REFRESH_CMD) begin
						state_q <= S_AY; // RULE_19
					end else begin
						state_q <= S_DONE;
						if (op_q == LLDC_OP_WRITE) begin
							cnt_q <= rl - 4'h2;
							state_q <= S_WLAT;
						end
						if (op_q == LLDC_OP_READ) begin
							to_q <= 6'h0;
							state_q <= S_RWAIT;
						end
					end
				end
				S_AY: begin
					state_q <= S_DONE;
					if (op_q == LLDC_OP_WRITE) begin
						cnt_q <= rl - 4'h3;
						state_q <= S_WLAT;
					end
					if (op_q == LLDC_OP_READ) begin
						to_q <= 6'h0;
						state_q <= S_RWAIT;
					end
				end
				S_WLAT: begin
					// Counts read latency plus one from the command edge
					if (cnt_q == 4'h0) begin
						beat_q <= 2'h0;
						state_q <= S_WDATA; // RULE_05
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				S_WDATA: begin
					beat_q <= beat_q + 2'h1;
					if (beat_q == 2'h1) begin
						state_q <= S_DONE; // RULE_04
					end
				end
				S_RWAIT: begin
					to_q <= to_q + 6'h1;
					if (rv_sync_q[2]) begin
						rdata_q <= {14'h0, dq_s1_q}; // RULE_08
						state_q <= S_DONE;
					end else if (to_q == LLDC_RD_TIMEOUT) begin
						err_q <= 1'b1;
						state_q <= S_DONE;
					end
				end
				S_DONE: begin
					// Second read beat follows the first by one clock
					if (op_q == LLDC_OP_READ && !err_q) begin
						rdata_q[31:18] <= dq_s1_q[13:0]; // RULE_08
					end
					busy_q <= 1'b0;
					done_q <= (op_q != LLDC_OP_BANK_REFRESH_CMD) || done_q;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
	// ********************************************************************
	// Pin drivers
	// ********************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			mem_cmd <= '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, ba: 3'h0, a: 21'h0};
		end else begin
			mem_cmd <= '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, ba: 3'h0, a: 21'h0};
			if (state_q == S_WAIT && !bank_busy[issue_bank] &&
				!(op_q == LLDC_OP_MRS && illegal)) begin
				mem_cmd.cs_n <= 1'b0;
				mem_cmd.ba <= issue_bank; // RULE_20
				mem_cmd.we_n <= !(op_q == LLDC_OP_WRITE || op_q == LLDC_OP_MRS);
				mem_cmd.ref_n <= !(op_q == LLDC_OP_MRS || op_q == LLDC_OP_BANK_REFRESH_CMD);
				if (op_q == LLDC_OP_MRS) begin
					mem_cmd.a <= {3'h0, addr_q[17:0]};
					if (mux_mode) begin
						mem_cmd.a[17:10] <= 8'h00; // RULE_22
					end
				end else if (op_q != LLDC_OP_BANK_REFRESH_CMD) begin
					mem_cmd.a <= addr_q[20:0]; // RULE_14
				end
			end else if (state_q == S_CMD && mux_mode && op_q != LLDC_OP_BANK_REFRESH_CMD) begin
				mem_cmd.a <= {10'h0, addr_q[31:21]}; // RULE_19
			end
		end
	end
	// Write clock pulses high for the first beat only; data beats on both edges
	always_ff @(posedge clock) begin
		if (reset) begin
			write_data_clock <= 1'b0;
			mem_wbeat <= '{dq: 18'h0, dm: 1'b0};
			mem_dq_oe <= 1'b0;
		end else begin
			write_data_clock <= state_q == S_WDATA && beat_q == 2'h0;
			mem_dq_oe <= state_q == S_WDATA; // RULE_13 RULE_07
			mem_wbeat.dq <= (beat_q == 2'h0) ? wdata_q[17:0] : {4'h0, wdata_q[31:18]};
			mem_wbeat.dm <= ctrl_q[8 + beat_q[0]]; // RULE_06
		end
	end
	a_wr_latency: assert property (@(posedge clock) disable iff (reset)
		(state_q == S_WLAT && cnt_q == 4'h0) |=> state_q == S_WDATA ##1 mem_dq_oe
	) else $error("write data not started after latency"); // RULE_05
	a_cmd_idle_hi: assert property (@(posedge clock) disable iff (reset)
		state_q == S_IDLE |=> mem_cmd.cs_n) else $error("command outside sequence"); // RULE_19
	a_mrs_hi_zero: assert property (@(posedge clock) disable iff (reset)
		(!mem_cmd.cs_n && !mem_cmd.we_n && !mem_cmd.ref_n && mux_mode) |-> mem_cmd.a[17:10] == 8'h0
	) else $error("mode load upper bits not zero"); // RULE_22
	a_no_bl8_cfg1: assert property (@(posedge clock) disable iff (reset)
		mode_q[2:0] == 3'h1 |-> mode_q[LLDC_MODE_BL_LSB +: 2] != LLDC_BL8
	) else $error("burst eight with configuration 1"); // RULE_03
	a_wr_two_beats: assert property (@(posedge clock) disable iff (reset)
		$rose(mem_dq_oe) |-> ##1 mem_dq_oe ##1 !mem_dq_oe
	) else $error("write burst length wrong"); // RULE_04
endmodule // lldc_ctrl

/* File: lldc_pkg.sv */
// Package with constants, types and command codes for the low latency DRAM controller
//
// Behaviour
// [RULE_01] Row cycle is 4, 6 or 8 clocks for configuration 1, 2, 3.
// [RULE_02] Only allowed configurations for the clock rate are ever programmed.
// [RULE_03] Burst length eight is never used with configuration 1.
// [RULE_04] Writes carry bank and row; data goes on both write clock edges.
// [RULE_05] Write latency is read latency plus one; first beat on rising edge.
// [RULE_06] Beats with mask high are not stored by the memory.
// [RULE_07] A write may be followed by a read with latency spacing kept.
// [RULE_08] Reads carry bank and row; data returns edge-aligned to strobes.
// [RULE_09] The memory raises read valid half a clock before data.
// [RULE_10] Strobe 0 times the lower data half, strobe 1 the upper half.
// [RULE_11] Data outputs float after a burst with nothing pending.
// [RULE_12] Back to back reads give an unbroken data stream.
// [RULE_13] A read may be followed by a write without data collision.
// [RULE_14] Refresh uses an internal row counter; address pins are ignored.
// [RULE_15] After refresh to a bank wait a row cycle before using it.
// [RULE_16] Every row of every bank is refreshed within each 32 ms; the default 25-clock interval per bank refresh takes 32.77 ms.
// [RULE_17] Address bit 9 set in mode load turns on data termination.
// [RULE_18] Termination goes off before read data and back on after.
// [RULE_19] Multiplexed mode sends address in two halves on two edges.
// [RULE_20] Bank address travels with command and first address half.
// [RULE_21] Mode bit 5 set enables multiplexed address mode.
// [RULE_22] Mode load in multiplexed mode drives address bits 17 to 10 zero.
// [RULE_23] Mode load samples address 17 to 0; may be rewritten any time.
// [RULE_24] Multiplexed mode adds one cycle to read and write latency.
// [RULE_25] A bank gets no new command until its row cycle has elapsed.
package lldc_pkg;
	// ********************************************************************
	// Avalon register map (word addresses)
	// ********************************************************************
	localparam logic [3:0] LLDC_REG_CTRL = 4'h0;
	localparam logic [3:0] LLDC_REG_ADDR = 4'h1;
	localparam logic [3:0] LLDC_REG_WDATA = 4'h2;
	localparam logic [3:0] LLDC_REG_RDATA = 4'h3;
	localparam logic [3:0] LLDC_REG_STATUS = 4'h4;
	localparam logic [3:0] LLDC_REG_MODE = 4'h5;
	localparam logic [3:0] LLDC_REG_REFI = 4'h6;
	localparam logic [31:0] LLDC_UNMAPPED = 32'hdead_beef;
	// ********************************************************************
	// Commands and mode fields
	// ********************************************************************
	localparam logic [1:0] LLDC_OP_READ = 2'h0;
	localparam logic [1:0] LLDC_OP_WRITE = 2'h1;
	localparam logic [1:0] LLDC_OP_MRS = 2'h2;
	localparam logic [1:0] LLDC_OP_BANK_REFRESH_CMD = 2'h3;
	localparam int LLDC_MODE_CFG_LSB = 0;
	localparam int LLDC_MODE_BL_LSB = 3;
	localparam int LLDC_MODE_MUX_BIT = 5;
	localparam int LLDC_MODE_ODT_BIT = 9;
	localparam logic [17:0] LLDC_MODE_RESET = 18'h00000;
	localparam logic [1:0] LLDC_BL2 = 2'h0;
	localparam logic [1:0] LLDC_BL4 = 2'h1;
	localparam logic [1:0] LLDC_BL8 = 2'h2;
	localparam int LLDC_NBANK = 8;
	localparam int LLDC_ROWS_PER_BANK = 8192;
	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int LLDC_CLK_MHZ = 50;
	localparam int LLDC_REFRESH_MS = 32;
	localparam int LLDC_REFI_CYCLES =
		(LLDC_REFRESH_MS * 1000 * LLDC_CLK_MHZ) / (LLDC_ROWS_PER_BANK * LLDC_NBANK);
	localparam logic [3:0] LLDC_TRC_CFG1 = 4'h4;
	localparam logic [3:0] LLDC_TRC_CFG2 = 4'h6;
	localparam logic [3:0] LLDC_TRC_CFG3 = 4'h8;
	localparam logic [3:0] LLDC_RL_CFG1 = 4'h4;
	localparam logic [3:0] LLDC_RL_CFG2 = 4'h6;
	localparam logic [3:0] LLDC_RL_CFG3 = 4'h8;
	localparam logic [5:0] LLDC_RD_TIMEOUT = 6'h3f;
	// ********************************************************************
	// Pin bundles
	// ********************************************************************
	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic ref_n;
		logic [2:0] ba;
		logic [20:0] a;
	} lldc_cmd_s;
	typedef struct packed {
		logic [17:0] dq;
		logic dm;
	} lldc_wbeat_s;
	// Row cycle for a configuration code
	function automatic logic [3:0] lldc_trc(input logic [2:0] cfg);
		case (cfg)
			3'h2: lldc_trc = LLDC_TRC_CFG2;
			3'h3: lldc_trc = LLDC_TRC_CFG3;
			default: lldc_trc = LLDC_TRC_CFG1;
		endcase
	endfunction
	// Read latency for a configuration code, mux mode adds one
	function automatic logic [3:0] lldc_rl(input logic [2:0] cfg, input logic mux);
		logic [3:0] r;
		case (cfg)
			3'h2: r = LLDC_RL_CFG2;
			3'h3: r = LLDC_RL_CFG3;
			default: r = LLDC_RL_CFG1;
		endcase
		lldc_rl = r + {3'h0, mux};
	endfunction
endpackage

/* File: lldc_bank_timer.sv */
// Per-bank row cycle busy counters
module lldc_bank_timer (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Bank issue
	input wire logic issue,
	input wire logic [2:0] bank,
	input wire logic [3:0] trc,
	// Busy view
	output logic [7:0] busy
);
	import lldc_pkg::*;
	logic [3:0] cnt_q [LLDC_NBANK];
	always_ff @(posedge clock) begin
		for (int i = 0; i < LLDC_NBANK; i++) begin
			if (reset) begin
				cnt_q[i] <= 4'h0;
			end else if (issue && bank == i[2:0]) begin
				cnt_q[i] <= trc - 4'h1; // RULE_25
			end else if (cnt_q[i] != 4'h0) begin
				cnt_q[i] <= cnt_q[i] - 4'h1;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < LLDC_NBANK; i++) begin
			busy[i] = (cnt_q[i] != 4'h0);
		end
	end
	a_bank_busy_after: assert property (@(posedge clock) disable iff (reset)
		issue |=> busy[$past(bank)]) else $error("bank not busy after issue"); // RULE_15
endmodule // lldc_bank_timer

/* File: lldc_mem_model.sv */
// Behavioural model of the low latency DRAM on the far side of the controller
module lldc_mem_model (
	// Clock
	input wire logic clock,
	// Controller pins
	input wire lldc_pkg::lldc_cmd_s mem_cmd,
	input wire logic write_data_clock,
	input wire lldc_pkg::lldc_wbeat_s mem_wbeat,
	input wire logic mem_dq_oe,
	// Read pins
	output logic [17:0] mem_dq_in,
	output logic read_valid_flag,
	output logic [1:0] read_data_strobe,
	// Observation
	output int viol,
	output logic [17:0] mode_q,
	output int ref_cnt [8]
);
	timeunit 1ns;
	timeprecision 1ps;
	import lldc_pkg::*;
	logic [35:0] mem [logic [34:0]];
	logic [34:0] rq_k [$];
	int rq_t [$];
	int last [8];
	int rrow [8];
	int cyc, wt, ct;
	logic [34:0] pk, wk;
	logic [35:0] cur;
	logic [1:0] op;
	logic [3:0] trc, rl;
	logic pend, mux, bi, wbi, drive, on_die_termination, nxt;
	always_comb begin
		case (mode_q[2:0])
			3'h2: trc = 4'h6;
			3'h3: trc = 4'h8;
			default: trc = 4'h4;
		endcase
		rl = trc + {3'h0, mode_q[5]};
	end
	initial begin
		{pend, bi, wbi, drive, on_die_termination, nxt, read_valid_flag} = 7'h0;
		{mode_q, read_data_strobe, mem_dq_in} = '0;
		viol = 0;
		cyc = 0;
		for (int i = 0; i < 8; i++) begin
			last[i] = -100;
			rrow[i] = 0;
			ref_cnt[i] = 0;
		end
	end
	task automatic fin(input logic [34:0] k);
		if (op == 2'b01) begin
			wk = k;
			wt = ct + rl + 1;
			if (!mem.exists(k)) mem[k] = 36'h0;
		end
		if (op == 2'b11) begin
			rq_k.push_back(k);
			rq_t.push_back(ct + rl);
		end
	endtask
	always @(posedge clock) begin
		cyc++;
		if (mem_dq_oe && drive) viol++;
		if (wbi) begin
			if (!mem_wbeat.dm) mem[wk][35:18] = mem_wbeat.dq;
			wbi = 1'b0;
		end else if (write_data_clock) begin
			if (cyc != wt) viol++;
			if (!mem_wbeat.dm) mem[wk][17:0] = mem_wbeat.dq;
			wbi = 1'b1;
		end
		if (pend) begin
			pend = 1'b0;
			fin({pk[34:11], mem_cmd.a[10:0]});
		end else if (!mem_cmd.cs_n) begin
			op = {mem_cmd.we_n, mem_cmd.ref_n};
			ct = cyc;
			mux = mode_q[5];
			if (op != 2'b00) begin
				if (cyc - last[mem_cmd.ba] < trc) viol++;
				last[mem_cmd.ba] = cyc;
			end
			if (op == 2'b10) begin
				rrow[mem_cmd.ba]++;
				ref_cnt[mem_cmd.ba]++;
			end
			if (op == 2'b00) begin
				if (mem_cmd.a[17:10] != 8'h00 || mem_cmd.a[2:0] > 3'h3) viol++;
				if (mem_cmd.a[2:0] == 3'h1 && mem_cmd.a[4:3] == 2'h2) viol++;
				mode_q = mem_cmd.a[17:0];
			end
			pk = {mem_cmd.ba, mem_cmd.a, 11'h000};
			if (mux && op != 2'b10) pend = 1'b1;
			else fin(pk);
		end
		if (bi) begin
			mem_dq_in <= cur[35:18];
			read_data_strobe <= 2'b00;
			bi = 1'b0;
		end else if (rq_t.size() != 0 && rq_t[0] <= cyc) begin
			cur = mem.exists(rq_k[0]) ? mem[rq_k[0]] : 36'h0;
			void'(rq_k.pop_front());
			void'(rq_t.pop_front());
			mem_dq_in <= cur[17:0];
			read_data_strobe <= 2'b11;
			bi = 1'b1;
			drive = 1'b1;
		end else begin
			mem_dq_in <= ~mem_dq_in;
			drive = 1'b0;
		end
	end
	always @(negedge clock) begin
		nxt = rq_t.size() != 0 && rq_t[0] <= cyc + 1;
		read_valid_flag <= bi || nxt;
		on_die_termination <= mode_q[9] && !drive && !nxt;
	end
endmodule // lldc_mem_model

/* File: lldc_testbench.sv */
// Self-checking bench for the low latency DRAM controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import lldc_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd, a, d;
	logic avs_waitrequest, write_data_clock, mem_dq_oe, read_valid_flag;
	lldc_cmd_s mem_cmd;
	lldc_wbeat_s mem_wbeat;
	logic [17:0] mem_dq_in, mode_q;
	logic [1:0] read_data_strobe;
	logic [31:0] modes [4];
	int viol;
	int ref_cnt [8];
	int miscompares = 0;
	int n_compared = 0;
	always #10 clock = ~clock;
	lldc_ctrl dut_u (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .mem_cmd, .write_data_clock, .mem_wbeat,
		.mem_dq_oe, .mem_dq_in, .read_valid_flag, .read_data_strobe);
	lldc_mem_model mem_u (.clock, .mem_cmd, .write_data_clock, .mem_wbeat, .mem_dq_oe,
		.mem_dq_in, .read_valid_flag, .read_data_strobe, .viol, .mode_q, .ref_cnt);
	// ********************************************************************
	// Tasks
	// ********************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		if (n >= 200) begin
			miscompares++;
			conclude();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic op(input logic [1:0] code, input logic [1:0] mask);
		int n;
		n = 0;
		bus(1'b1, LLDC_REG_CTRL, {1'b1, 21'h0, mask, 6'h0, code});
		do begin
			bus(1'b0, LLDC_REG_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wr_word(input logic [31:0] ad, input logic [31:0] wd, input logic [1:0] m);
		bus(1'b1, LLDC_REG_ADDR, ad);
		bus(1'b1, LLDC_REG_WDATA, wd);
		op(LLDC_OP_WRITE, m);
	endtask
	task automatic rd_word(input logic [31:0] ad);
		bus(1'b1, LLDC_REG_ADDR, ad);
		op(LLDC_OP_READ, 2'h0);
		bus(1'b0, LLDC_REG_RDATA, 32'h0);
	endtask
	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		modes = '{32'h00000009, 32'h00000012, 32'h0000020b, 32'h00000029};
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		bus(1'b0, LLDC_REG_STATUS, 32'h0);
		check("status", rd & 32'hd, 32'h0);
		bus(1'b0, LLDC_REG_MODE, 32'h0);
		check("mode", rd, {14'h0, LLDC_MODE_RESET});
		bus(1'b0, 4'hf, 32'h0);
		check("unmapped", rd, LLDC_UNMAPPED);
		bus(1'b1, LLDC_REG_REFI, 32'h10);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, LLDC_REG_ADDR, modes[i]);
			op(LLDC_OP_MRS, 2'h0);
			check("mode load", {14'h0, mode_q}, modes[i]);
			bus(1'b0, LLDC_REG_MODE, 32'h0);
			check("mode reg", rd, modes[i]);
			for (int b = 0; b < 8; b += 3) begin
				a = {8'h00, 3'(b), 21'(32'h1234 + i)};
				d = 32'h9a5c3e71 ^ {i[7:0], 16'h0, b[7:0]};
				wr_word(a, d, 2'h0);
				rd_word(a);
				check("read", rd, d);
				wr_word(a, ~d, 2'h2);
				rd_word(a);
				check("mask hi", rd, {d[31:18], ~d[17:0]});
				wr_word(a, ~d, 2'h1);
				rd_word(a);
				check("mask lo", rd, ~d);
			end
			$display("test mode %0d done", i);
		end
		bus(1'b1, LLDC_REG_ADDR, 32'h11);
		op(LLDC_OP_MRS, 2'h0);
		bus(1'b0, LLDC_REG_STATUS, 32'h0);
		check("err", {31'h0, rd[3]}, 32'h1);
		check("mode kept", {14'h0, mode_q}, modes[3]);
		$display("test illegal mode done");
		for (int k = 0; k < 8; k++) check("refresh", {31'h0, ref_cnt[k] > 0}, 32'h1);
		check("violations", viol, 32'h0);
		conclude();
	end
endmodule // testbench
